// ==== hw/hmsr_top.sv ====
// Harvest monitor and sleep register bank behind a two-wire serial register port.
// Assumes the boost converter, measurement sequencer and wake comparator sit on the other ports.
`timescale 1ns/10ps
`default_nettype none
`include "hmsr_regs.svh"

// Contract
// - Keep latest open-circuit voltage as 8-bit code, 10 mV per step.
// - Reading the voltage register starts nothing and sets no force flag.
// - Host write to voltage register replaces the stored result.
// - Voltage updated below 0x1D halts boost and enters sleep.
// - Low-voltage sleep lasts until next measurement or higher written value.
// - Sixteen-bit pulse counter read as upper byte and lower byte.
// - Pulse count is valid only while output rail exceeds wake threshold.
// - Pulse counter saturates at 0xFFFF instead of wrapping.
// - Pulse counter holds its value during sleep.
// - Sleep entered from harvest-count threshold lasts until next measurement or a written voltage of 0x1D or more.
// - Eight-bit threshold compared against the sixteen-bit pulse count.
// - Threshold zero disables count-based sleep.
// - Period code selects 64, 128, 256 measure times; code 3 disables.
// - Force request starts a measurement, then the request flag clears.
module hmsr_top #(
   parameter logic [6:0] DEV_ADDR = `HMSR_I2C_ADDR
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic inductor_switch_node,
   input wire logic system_output_rail_ok,
   input wire logic [1:0] measure_period_sel,
   input wire logic measure_time_tick,
   input wire logic force_measure_request,
   input wire logic measure_done,
   input wire logic [7:0] open_circuit_voltage_code,
   output logic measure_start,
   output logic sleep_mode,
   output logic boost_halt,
   output logic count_valid,
   output hmsr_pkg::hmsr_count_t harvest_pulse_count
);
   import hmsr_pkg::*;

   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic lx_s1, lx_s2, lx_s3, rail_s1, rail_s2;
   hmsr_i2c_e state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg, pointer, rd_mux;
   logic first_byte, is_read, master_nack, sda_drive_low;
   logic [7:0] open_circuit_voltage_result, sleep_count_threshold;
   logic forced_voltage_measure, period_due, meas_busy;
   logic [8:0] period_cnt, period_limit;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic reg_wr, voc_wr, lx_edge, thr_low, voc_low_meas;

   // Two-flop synchronisers, third stage only for edge detection
   always_ff @(posedge mclk) begin
      if (reset) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         lx_s1 <= 1'b0;
         lx_s2 <= 1'b0;
         lx_s3 <= 1'b0;
         rail_s1 <= 1'b0;
         rail_s2 <= 1'b0;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         lx_s1 <= inductor_switch_node;
         lx_s2 <= lx_s1;
         lx_s3 <= lx_s2;
         rail_s1 <= system_output_rail_ok;
         rail_s2 <= rail_s1;
      end
   end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_cond = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
   assign stop_cond = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
   assign lx_edge = lx_s2 & ~lx_s3;
   assign reg_wr = scl_fall && state == HMSR_WRITE && bit_cnt == `HMSR_BYTE_BITS && !first_byte;
   assign voc_wr = reg_wr && pointer == `HMSR_OFS_VOC;
   assign sda_out = 1'b0;
   assign sda_oe = sda_drive_low;
   assign boost_halt = sleep_mode;

   // Read data; reads have no side effect on measurement or force flag
   always_comb begin
      unique case (pointer)
         `HMSR_OFS_VOC: rd_mux = open_circuit_voltage_result;
         `HMSR_OFS_CNT_HI: rd_mux = harvest_pulse_count[15:8];
         `HMSR_OFS_CNT_LO: rd_mux = harvest_pulse_count[7:0];
         `HMSR_OFS_THR: rd_mux = sleep_count_threshold;
         default: rd_mux = `HMSR_READ_IDLE;
      endcase
   end

   // Serial register port: address, pointer, data with auto-increment
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= HMSR_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         pointer <= 8'h00;
         first_byte <= 1'b1;
         is_read <= 1'b0;
         master_nack <= 1'b0;
         sda_drive_low <= 1'b0;
      end else if (start_cond) begin
         state <= HMSR_ADDR;
         bit_cnt <= 4'h0;
         first_byte <= 1'b1;
         sda_drive_low <= 1'b0;
      end else if (stop_cond) begin
         state <= HMSR_IDLE;
         sda_drive_low <= 1'b0;
      end else if (scl_rise) begin
         if (state == HMSR_ADDR || state == HMSR_WRITE) begin
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (state == HMSR_RACK) begin
            master_nack <= sda_s2;
         end
      end else if (scl_fall) begin
         unique case (state)
            HMSR_ADDR: begin
               if (bit_cnt == `HMSR_BYTE_BITS) begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     is_read <= shreg[0];
                     sda_drive_low <= 1'b1;
                     state <= HMSR_ACK;
                  end else begin
                     state <= HMSR_IDLE;
                  end
               end
            end
            HMSR_WRITE: begin
               if (bit_cnt == `HMSR_BYTE_BITS) begin
                  if (first_byte) begin
                     pointer <= shreg;
                  end else begin
                     pointer <= pointer + 8'h01;
                  end
                  first_byte <= 1'b0;
                  sda_drive_low <= 1'b1;
                  state <= HMSR_ACK;
               end
            end
            HMSR_ACK: begin
               bit_cnt <= 4'h0;
               if (is_read) begin
                  shreg <= {rd_mux[6:0], 1'b0};
                  sda_drive_low <= ~rd_mux[7];
                  pointer <= pointer + 8'h01;
                  bit_cnt <= 4'h1;
                  state <= HMSR_READ;
               end else begin
                  sda_drive_low <= 1'b0;
                  state <= HMSR_WRITE;
               end
            end
            HMSR_READ: begin
               if (bit_cnt == `HMSR_BYTE_BITS) begin
                  sda_drive_low <= 1'b0;
                  state <= HMSR_RACK;
               end else begin
                  sda_drive_low <= ~shreg[7];
                  shreg <= {shreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            HMSR_RACK: begin
               if (master_nack) begin
                  state <= HMSR_IDLE;
               end else begin
                  shreg <= {rd_mux[6:0], 1'b0};
                  sda_drive_low <= ~rd_mux[7];
                  pointer <= pointer + 8'h01;
                  bit_cnt <= 4'h1;
                  state <= HMSR_READ;
               end
            end
            default: state <= HMSR_IDLE;
         endcase
      end
   end

   // Threshold register
   always_ff @(posedge mclk) begin
      if (reset) begin
         sleep_count_threshold <= `HMSR_THR_RESET;
      end else if (reg_wr && pointer == `HMSR_OFS_THR) begin
         sleep_count_threshold <= shreg;
      end
   end

   // Voltage result: measurement wins over a simultaneous host write
   always_ff @(posedge mclk) begin
      if (reset) begin
         open_circuit_voltage_result <= `HMSR_VOC_RESET;
      end else if (measure_done) begin
         open_circuit_voltage_result <= open_circuit_voltage_code;
      end else if (voc_wr) begin
         open_circuit_voltage_result <= shreg;
      end
   end

   // Measurement scheduling: periodic and forced requests
   always_comb begin
      unique case (measure_period_sel)
         2'h0: period_limit = `HMSR_PER_BASE;
         2'h1: period_limit = `HMSR_PER_X2;
         default: period_limit = `HMSR_PER_X4;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         period_cnt <= 9'h000;
         period_due <= 1'b0;
      end else begin
         if (measure_period_sel == `HMSR_PER_OFF) begin
            period_cnt <= 9'h000;
         end else if (measure_time_tick) begin
            period_cnt <= (period_cnt == period_limit - 9'h001) ? 9'h000 : period_cnt + 9'h001;
         end
         if (measure_period_sel != `HMSR_PER_OFF && measure_time_tick && period_cnt == period_limit - 9'h001) begin
            period_due <= 1'b1;
         end else if (measure_start) begin
            period_due <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         forced_voltage_measure <= 1'b0;
      end else if (force_measure_request) begin
         forced_voltage_measure <= 1'b1;
      end else if (measure_start) begin
         forced_voltage_measure <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         measure_start <= 1'b0;
         meas_busy <= 1'b0;
      end else begin
         measure_start <= (forced_voltage_measure | period_due) & ~meas_busy & ~measure_start;
         if (measure_start) begin
            meas_busy <= 1'b1;
         end else if (measure_done) begin
            meas_busy <= 1'b0;
         end
      end
   end

   // Sleep decision
   assign voc_low_meas = open_circuit_voltage_code < `HMSR_VOC_RESET;
   assign thr_low = sleep_count_threshold != `HMSR_THR_OFF
      && harvest_pulse_count < {8'h00, sleep_count_threshold};

   always_ff @(posedge mclk) begin
      if (reset) begin
         sleep_mode <= 1'b0;
      end else if (measure_done) begin
         sleep_mode <= voc_low_meas | thr_low;
      end else if (measure_start) begin
         sleep_mode <= 1'b0;
      end else if (voc_wr) begin
         sleep_mode <= shreg < `HMSR_VOC_RESET;
      end
   end

   // Pulse counter: saturating, frozen in sleep, restarted after each evaluation
   always_ff @(posedge mclk) begin
      if (reset) begin
         harvest_pulse_count <= `HMSR_CNT_RESET;
      end else if (measure_done) begin
         harvest_pulse_count <= `HMSR_CNT_RESET;
      end else if (lx_edge && !sleep_mode && harvest_pulse_count != `HMSR_CNT_FULL) begin
         harvest_pulse_count <= harvest_pulse_count + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         count_valid <= 1'b0;
      end else begin
         count_valid <= rail_s2;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_voc_meas_store: assert property (measure_done |=>
      open_circuit_voltage_result == $past(open_circuit_voltage_code)) else $error("voltage result not stored");
   a_voc_host_write: assert property (voc_wr && !measure_done |=>
      open_circuit_voltage_result == $past(shreg)) else $error("host write not stored");
   a_low_voc_sleep: assert property (voc_wr && !measure_done && !measure_start && shreg < `HMSR_VOC_RESET
      |=> sleep_mode && boost_halt) else $error("low voltage did not halt boost");
   a_sleep_holds: assert property (sleep_mode && !measure_start && !measure_done && !voc_wr
      |=> sleep_mode) else $error("sleep left without cause");
   a_count_saturate: assert property (harvest_pulse_count == `HMSR_CNT_FULL && !measure_done
      |=> harvest_pulse_count == `HMSR_CNT_FULL) else $error("counter wrapped");
   a_count_frozen: assert property (sleep_mode && !measure_done |=>
      $stable(harvest_pulse_count)) else $error("counter moved in sleep");
   a_thr_sleep: assert property (measure_done && sleep_count_threshold != 8'h00
      && harvest_pulse_count < {8'h00, sleep_count_threshold} |=> sleep_mode) else $error("threshold sleep missed");
   a_thr_zero_off: assert property (measure_done && sleep_count_threshold == 8'h00
      && !voc_low_meas |=> !sleep_mode) else $error("zero threshold caused sleep");
   a_force_starts: assert property ($rose(forced_voltage_measure) && !meas_busy && !measure_start
      |-> ##[1:2] measure_start ##1 !forced_voltage_measure) else $error("forced measure not started");
   a_period_off: assert property (measure_period_sel == 2'h3 |=> !$rose(period_due))
      else $error("disabled period fired");
   a_rail_valid: assert property (rail_s2 |=> count_valid) else $error("count valid not following rail");

   c_forced_meas: cover property (force_measure_request ##[1:3] measure_start);
   c_low_voc_write: cover property (voc_wr && shreg < `HMSR_VOC_RESET ##1 sleep_mode);
   c_thr_sleep: cover property (measure_done && thr_low ##1 sleep_mode);
   c_count_full: cover property (harvest_pulse_count == `HMSR_CNT_FULL);
endmodule
`default_nettype wire

// ==== hw/hmsr_regs.svh ====
// Register offsets, reset values and timing figures of the harvest monitor and sleep register bank.
// Assumes inclusion by its bare name from the design module and the bench files.
`ifndef HMSR_REGS_SVH
`define HMSR_REGS_SVH

`define HMSR_OFS_VOC 8'h09
`define HMSR_OFS_CNT_HI 8'h0A
`define HMSR_OFS_CNT_LO 8'h0B
`define HMSR_OFS_THR 8'h0C

`define HMSR_VOC_RESET 8'h1D
`define HMSR_CNT_RESET 16'h0000
`define HMSR_CNT_FULL 16'hFFFF
`define HMSR_THR_RESET 8'h00
`define HMSR_THR_OFF 8'h00
`define HMSR_READ_IDLE 8'h00

`define HMSR_PER_BASE 9'h040
`define HMSR_PER_X2 9'h080
`define HMSR_PER_X4 9'h100
`define HMSR_PER_OFF 2'h3

// Serial bus address; the value is arbitrary
`define HMSR_I2C_ADDR 7'h2A
`define HMSR_BYTE_BITS 4'h8

`endif

// ==== hw/hmsr_pkg.sv ====
// Types shared by the harvest monitor and sleep register bank.
// Assumes the register header sits beside it.
package hmsr_pkg;
   typedef enum logic [2:0] {
      HMSR_IDLE = 3'b000,
      HMSR_ADDR = 3'b001,
      HMSR_ACK = 3'b010,
      HMSR_WRITE = 3'b011,
      HMSR_READ = 3'b100,
      HMSR_RACK = 3'b101
   } hmsr_i2c_e;
   typedef logic [15:0] hmsr_count_t;
endpackage

// ==== tb/hmsr_i2c_host.sv ====
// I2C host model driving the serial register port of the register bank.
// Assumes an open-drain data wire with pull-up, clocked from the bench's mclk.
`timescale 1ns/10ps
`default_nettype none
`include "hmsr_regs.svh"
module hmsr_i2c_host (
   input wire logic mclk,
   input wire logic sda_oe,
   input wire logic sda_out,
   output logic scl,
   output logic sda
);
   logic low = 1'b0;
   initial scl = 1'b1;
   // Pull-up wins unless a party pulls low
   assign sda = (low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Data moves mid-low, read at the end of the high phase
   task automatic clock_bit(input logic b, output logic r);
      scl <= 1'b0;
      wait_n(4);
      low <= !b;
      wait_n(4);
      scl <= 1'b1;
      wait_n(8);
      r = sda;
   endtask
   // START when s is 1, STOP when s is 0
   task automatic frame(input logic s);
      @(posedge mclk);
      scl <= 1'b0;
      wait_n(4);
      low <= !s;
      wait_n(4);
      scl <= 1'b1;
      wait_n(8);
      low <= s;
      wait_n(8);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) clock_bit(d[i], q[i]);
      clock_bit(ack_out, nak);
   endtask
   task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val, output logic ok);
      logic [7:0] q;
      logic n0, n1, n2;
      frame(1'b1);
      xfer({`HMSR_I2C_ADDR, 1'b0}, 1'b1, q, n0);
      xfer(ofs, 1'b1, q, n1);
      xfer(val, 1'b1, q, n2);
      frame(1'b0);
      ok = !(n0 || n1 || n2);
   endtask
   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val, output logic ok);
      logic [7:0] q;
      logic n0, n1, n2, n3;
      frame(1'b1);
      xfer({`HMSR_I2C_ADDR, 1'b0}, 1'b1, q, n0);
      xfer(ofs, 1'b1, q, n1);
      frame(1'b1);
      xfer({`HMSR_I2C_ADDR, 1'b1}, 1'b1, q, n2);
      xfer(8'hFF, 1'b1, val, n3);
      frame(1'b0);
      ok = !(n0 || n1 || n2);
   endtask
endmodule
`default_nettype wire

// ==== tb/hmsr_top_test.sv ====
// Self-checking bench for the harvest monitor and sleep register bank.
// Assumes the I2C host model and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "hmsr_regs.svh"
module hmsr_top_test;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic sw_node = 1'b0;
   logic rail_ok = 1'b1;
   logic [1:0] per_sel = 2'h3;
   logic tick = 1'b0;
   logic force_req = 1'b0;
   logic done = 1'b0;
   logic [7:0] code = 8'h00;
   wire logic scl;
   wire logic sda;
   logic sda_oe, sda_out, meas_start, sleep, halt, cnt_valid, ok;
   logic [7:0] rd;
   hmsr_pkg::hmsr_count_t cnt;
   int bad_count = 0;
   int checked = 0;
   int starts = 0;
   initial forever #25 mclk = ~mclk;
   hmsr_top i_dut (
      .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .inductor_switch_node(sw_node), .system_output_rail_ok(rail_ok), .measure_period_sel(per_sel),
      .measure_time_tick(tick), .force_measure_request(force_req), .measure_done(done),
      .open_circuit_voltage_code(code), .measure_start(meas_start), .sleep_mode(sleep),
      .boost_halt(halt), .count_valid(cnt_valid), .harvest_pulse_count(cnt));
   hmsr_i2c_host i_host (.mclk(mclk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
   always @(posedge mclk) if (meas_start === 1'b1) starts <= starts + 1;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_host.write_reg(a, v, ok);
      check({15'h0000, ok}, 16'h0001, "write ack");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      i_host.read_reg(a, rd, ok);
      check({ok, 7'h00, rd}, {8'h80, exp}, what);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         sw_node <= 1'b1;
         repeat (3) @(posedge mclk);
         sw_node <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
   endtask
   task automatic answer(input logic [7:0] c);
      done <= 1'b1;
      code <= c;
      @(posedge mclk);
      done <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Forced measurement; no register write overlaps the pending request
   task automatic measure(input logic [7:0] c);
      int base;
      base = starts;
      @(posedge mclk);
      force_req <= 1'b1;
      @(posedge mclk);
      force_req <= 1'b0;
      for (int i = 0; i < 6 && starts == base; i++) @(posedge mclk);
      check(16'(starts - base), 16'h0001, "forced start");
      if (starts == base) print_verdict();
      @(posedge mclk);
      check({15'h0000, sleep}, 16'h0000, "sleep ends at measure");
      answer(c);
   endtask
   task automatic t_reset_values();
      check({15'h0000, sleep}, 16'h0000, "sleep after reset");
      rd_chk(`HMSR_OFS_VOC, `HMSR_VOC_RESET, "voc reset");
      rd_chk(`HMSR_OFS_CNT_HI, 8'h00, "count high reset");
      rd_chk(`HMSR_OFS_CNT_LO, 8'h00, "count low reset");
      rd_chk(`HMSR_OFS_THR, 8'h00, "threshold reset");
      i_host.write_reg(`HMSR_OFS_CNT_HI, 8'h55, ok);
      rd_chk(`HMSR_OFS_CNT_HI, 8'h00, "read-only count");
      rd_chk(8'h0D, 8'h00, "unmapped read");
      check(16'(starts), 16'h0000, "reads start nothing");
   endtask
   task automatic t_period();
      int n, s0;
      for (int s = 0; s < 4; s++) begin
         per_sel <= 2'(s);
         s0 = starts;
         n = 0;
         while (starts == s0 && n < 300) begin
            @(posedge mclk);
            tick <= 1'b1;
            @(posedge mclk);
            tick <= 1'b0;
            repeat (4) @(posedge mclk);
            n++;
         end
         if (s < 3) begin
            check(16'(n), 16'(64 << s), "period length");
            if (n >= 300) print_verdict();
            answer(8'h40);
         end else begin
            check(16'(starts - s0), 16'h0000, "period off");
         end
      end
   endtask
   task automatic t_count();
      pulses(258);
      rd_chk(`HMSR_OFS_CNT_HI, 8'h01, "count high");
      rd_chk(`HMSR_OFS_CNT_LO, 8'h02, "count low");
      check({15'h0000, cnt_valid}, 16'h0001, "count valid");
      rail_ok <= 1'b0;
      repeat (5) @(posedge mclk);
      check({15'h0000, cnt_valid}, 16'h0000, "count invalid");
      rail_ok <= 1'b1;
      repeat (5) @(posedge mclk);
   endtask
   task automatic t_voc_sleep();
      wr(`HMSR_OFS_VOC, 8'h1C);
      rd_chk(`HMSR_OFS_VOC, 8'h1C, "voc override");
      check({14'h0000, sleep, halt}, 16'h0003, "written low voc sleeps");
      pulses(4);
      check(cnt, 16'h0102, "count held in sleep");
      wr(`HMSR_OFS_VOC, 8'h1D);
      check({14'h0000, sleep, halt}, 16'h0000, "higher voc wakes");
      measure(8'h1C);
      check({14'h0000, sleep, halt}, 16'h0003, "measured low voc sleeps");
      rd_chk(`HMSR_OFS_VOC, 8'h1C, "measured voc");
      measure(8'h40);
      check({15'h0000, sleep}, 16'h0000, "measured voc awake");
   endtask
   task automatic t_threshold();
      wr(`HMSR_OFS_THR, 8'h04);
      rd_chk(`HMSR_OFS_THR, 8'h04, "threshold readback");
      pulses(3);
      measure(8'h40);
      check({15'h0000, sleep}, 16'h0001, "count below threshold");
      wr(`HMSR_OFS_VOC, 8'h40);
      wr(`HMSR_OFS_THR, 8'h03);
      pulses(3);
      measure(8'h40);
      check({15'h0000, sleep}, 16'h0000, "count equals threshold");
      wr(`HMSR_OFS_THR, 8'h00);
      measure(8'h40);
      check({15'h0000, sleep}, 16'h0000, "threshold zero");
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset_values();
      t_period();
      t_count();
      t_voc_sleep();
      t_threshold();
      print_verdict();
   end
endmodule
`default_nettype wire
